// >>> shared/acl_pkg.sv
package acl_pkg;

   // Register byte offsets on the APB port.
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] status_off = 8'h04;
   localparam logic [7:0] cmd_two_off = 8'h08;
   localparam logic [7:0] cmd_word_off = 8'h0c;
   localparam logic [7:0] cmd_index_off = 8'h1c;
   localparam logic [7:0] cbp_off = 8'h20;
   localparam logic [7:0] list1_off_off = 8'h24;
   localparam logic [7:0] prs_off = 8'h28;

   // Control register field positions.
   localparam int ctrl_en_bit = 0;
   localparam int ctrl_smod_bit = 1;
   localparam int ctrl_start_bit = 2;
   localparam int ctrl_list_bit = 3;
   localparam int ctrl_lopt_lsb = 4;

   // Command word field positions.
   localparam int smp_lsb = 11;
   localparam int uopt_lsb = 9;
   localparam int chsel_lsb = 16;

   // Reset values.
   localparam logic [7:0] cmd_two_rst = 8'h00;
   localparam logic [23:0] cbp_rst = 24'h000000;
   localparam logic [6:0] prs_rst = 7'h00;
   localparam logic [6:0] list1_off_rst = 7'h20;

   // Limits.
   localparam logic [4:0] smp_max = 5'h14;
   localparam logic [4:0] smp_base = 5'h04;
   localparam logic [5:0] chan_max_dflt = 6'h14;
   localparam logic [5:0] chan_reserved_lo = 6'h03;
   localparam logic [5:0] chan_reserved_hi = 6'h07;

   typedef struct packed {
      logic [4:0] sample_time_code;
      logic [1:0] upper_system_option_bits;
      logic [5:0] input_channel_select;
   } acl_cmd_t;

   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_fetch = 4'b0010,
      st_sample = 4'b0100,
      st_halt = 4'b1000
   } acl_state_t;

endpackage

// >>> verilog/acl_clkdiv.sv
`timescale 1ns/1ns
module acl_clkdiv (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [6:0] clock_prescaler_value,
   output logic conv_tick
);
   logic [7:0] cnt_r;

   // Conversion clock period is 2*(prescaler+1) bus cycles; one tick per period.
   always_ff @(posedge ref_clk) begin
      if (!resetn || !run) begin
         cnt_r <= 8'h00;
      end else if (cnt_r >= {clock_prescaler_value, 1'b1}) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   assign conv_tick = run && (cnt_r >= {clock_prescaler_value, 1'b1});
endmodule // acl_clkdiv

// >>> verilog/acl_cmd_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// R1 - Reserved encoding in a fetched command sets the error flag and halts.
// R2 - Second command byte always readable, written only under special-mode access.
// R3 - Sample-time code gives code plus four conversion cycles; above 10100 is reserved.
// R4 - Sample cycles are counted in conversion-clock periods set by the prescaler.
// R5 - Command bits 10 to 9 drive the upper option bits beside the lower ones.
// R6 - Software changes the command byte only while no conversion is running.
// R7 - Read-only six-bit command index counts 32-bit entries from list start.
// R8 - Base pointer written only while converter disabled or special access set.
// R9 - Base pointer holds the word-aligned base address of both command lists.
// R10 - Fetch address is computed from the base pointer and the active list.
// R11 - Highest analog channel code matches the implemented channel count.
// R12 - Channel-select bits 21 to 16 choose the converted analog input.
// R13 - Command index advances by one after each command is loaded.
module acl_cmd_ctrl #(
   parameter logic [5:0] highest_analog_input = acl_pkg::chan_max_dflt
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic fetch_req,
   output logic [23:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_data,
   output logic [5:0] input_channel_select,
   output logic [3:0] system_option_bits,
   output logic sampling,
   output logic sample_done,
   output logic command_error_flag
);

   ////////////////////////////////////////////////////////////////////////////
   logic adc_en_r;
   logic special_mode_access_r;
   logic active_list_r;
   logic [1:0] lower_system_option_bits_r;
   logic [7:0] cmd_two_r;
   logic [5:0] chsel_r;
   logic [23:0] command_list_base_r;
   logic [5:0] command_list_index_r;
   logic [6:0] list1_offset_r;
   logic [6:0] clock_prescaler_value_r;
   logic command_error_flag_r;
   logic [4:0] smp_cnt_r;
   logic sample_done_r;
   logic [23:0] fetch_addr_r;
   logic [31:0] prdata_r;
   acl_pkg::acl_state_t state_r;
   acl_pkg::acl_state_t state_nxt;
   acl_pkg::acl_cmd_t cmd;
   logic wr;
   logic rd;
   logic start;
   logic conv_tick;
   logic bad_cmd;
   logic fetch_take;
   logic cmd_wr_ok;
   logic cfg_wr_ok;
   logic err_set;
   logic err_clr;
   logic [31:0] rd_word;

   function automatic logic chan_reserved(input logic [5:0] ch, input logic [5:0] hi);
      chan_reserved = (ch >= acl_pkg::chan_reserved_lo && ch <= acl_pkg::chan_reserved_hi) || (ch > hi);
   endfunction

   function automatic logic reg_mapped(input logic [7:0] a);
      unique case (a)
         acl_pkg::ctrl_off, acl_pkg::status_off, acl_pkg::cmd_two_off, acl_pkg::cmd_word_off: reg_mapped = 1'b1;
         acl_pkg::cmd_index_off, acl_pkg::cbp_off, acl_pkg::list1_off_off, acl_pkg::prs_off: reg_mapped = 1'b1;
         default: reg_mapped = 1'b0;
      endcase
   endfunction

   // Index and list offset count 32-bit entries, so both are scaled by four here.
   function automatic logic [23:0] entry_addr(input logic [23:0] base, input logic [6:0] off,
                                            input logic [5:0] idx);
      logic [7:0] words;
      words = {1'b0, off} + {2'b00, idx};
      entry_addr = {base[23:2], 2'b00} + {14'h0000, words, 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB answers in the access cycle; no wait states.
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !reg_mapped(paddr);
   assign start = wr && paddr == acl_pkg::ctrl_off && pwdata[acl_pkg::ctrl_start_bit];
   assign fetch_take = state_r == acl_pkg::st_fetch && fetch_ack;
   // Command writes need special access; setup registers also open while the converter is off.
   assign cmd_wr_ok = wr && special_mode_access_r; // R2
   assign cfg_wr_ok = wr && (!adc_en_r || special_mode_access_r); // R8

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         adc_en_r <= 1'b0;
         special_mode_access_r <= 1'b0;
      end else if (wr && paddr == acl_pkg::ctrl_off) begin
         adc_en_r <= pwdata[acl_pkg::ctrl_en_bit];
         special_mode_access_r <= pwdata[acl_pkg::ctrl_smod_bit];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         active_list_r <= 1'b0;
         lower_system_option_bits_r <= 2'b00;
      end else if (wr && paddr == acl_pkg::ctrl_off) begin
         active_list_r <= pwdata[acl_pkg::ctrl_list_bit];
         lower_system_option_bits_r <= pwdata[acl_pkg::ctrl_lopt_lsb +: 2];
      end
   end

   // Software must keep this idle while converting; hardware does not check it.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cmd_two_r <= acl_pkg::cmd_two_rst;
         chsel_r <= 6'h00;
      end else if (fetch_take) begin
         cmd_two_r <= fetch_data[15:8]; // R13
         chsel_r <= fetch_data[acl_pkg::chsel_lsb +: 6]; // R12
      end else if (cmd_wr_ok) begin // R2 R6
         if (paddr == acl_pkg::cmd_two_off) begin
            cmd_two_r <= pwdata[7:0];
         end else if (paddr == acl_pkg::cmd_word_off) begin
            cmd_two_r <= pwdata[15:8];
            chsel_r <= pwdata[acl_pkg::chsel_lsb +: 6];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         command_list_base_r <= acl_pkg::cbp_rst;
      end else if (cfg_wr_ok && paddr == acl_pkg::cbp_off) begin // R8
         command_list_base_r <= {pwdata[23:2], 2'b00}; // R9
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         list1_offset_r <= acl_pkg::list1_off_rst;
      end else if (cfg_wr_ok && paddr == acl_pkg::list1_off_off) begin
         list1_offset_r <= pwdata[6:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         clock_prescaler_value_r <= acl_pkg::prs_rst;
      end else if (cfg_wr_ok && paddr == acl_pkg::prs_off) begin
         clock_prescaler_value_r <= pwdata[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign cmd.sample_time_code = cmd_two_r[acl_pkg::smp_lsb - 8 +: 5];
   assign cmd.upper_system_option_bits = cmd_two_r[acl_pkg::uopt_lsb - 8 +: 2];
   assign cmd.input_channel_select = chsel_r;
   assign bad_cmd = cmd.sample_time_code > acl_pkg::smp_max // R1 R3
      || chan_reserved(cmd.input_channel_select, highest_analog_input); // R11

   // The divider runs only while sampling, so every window starts on a whole conversion period.
   acl_clkdiv u_div (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .run(state_r == acl_pkg::st_sample),
      .clock_prescaler_value(clock_prescaler_value_r),
      .conv_tick(conv_tick)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         acl_pkg::st_idle: begin
            if (start && adc_en_r) begin
               state_nxt = acl_pkg::st_fetch;
            end
         end
         acl_pkg::st_fetch: begin
            if (fetch_ack) begin
               state_nxt = acl_pkg::st_sample;
            end
         end
         acl_pkg::st_sample: begin
            if (bad_cmd) begin
               state_nxt = acl_pkg::st_halt; // R1
            end else if (conv_tick && smp_cnt_r == cmd.sample_time_code + acl_pkg::smp_base - 5'h01) begin
               state_nxt = acl_pkg::st_idle; // R3 R4
            end
         end
         acl_pkg::st_halt: begin
            // Only dropping the enable leaves a halt, so a bad list cannot run on by itself.
            if (!adc_en_r) begin
               state_nxt = acl_pkg::st_idle;
            end
         end
         default: begin
            state_nxt = acl_pkg::st_idle;
         end
      endcase
      if (!adc_en_r && state_r != acl_pkg::st_halt) begin
         state_nxt = acl_pkg::st_idle;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_r <= acl_pkg::st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The count restarts with every window, so a stale count never shortens the next one.
   always_ff @(posedge ref_clk) begin
      if (!resetn || state_r != acl_pkg::st_sample) begin
         smp_cnt_r <= 5'h00;
      end else if (conv_tick) begin
         smp_cnt_r <= smp_cnt_r + 5'h01; // R4
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sample_done_r <= 1'b0;
      end else begin
         sample_done_r <= state_r == acl_pkg::st_sample && state_nxt == acl_pkg::st_idle && adc_en_r;
      end
   end

   // Clearing the enable rewinds both lists to their first entry.
   always_ff @(posedge ref_clk) begin
      if (!resetn || !adc_en_r) begin
         command_list_index_r <= 6'h00;
      end else if (fetch_take) begin
         command_list_index_r <= command_list_index_r + 6'h01; // R13
      end
   end

   assign err_set = state_r == acl_pkg::st_sample && bad_cmd;
   assign err_clr = wr && paddr == acl_pkg::status_off && pwdata[0];

   // Error stays until software writes one to its status bit; a new error on that edge still wins.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         command_error_flag_r <= 1'b0;
      end else if (err_set) begin
         command_error_flag_r <= 1'b1; // R1
      end else if (err_clr) begin
         command_error_flag_r <= 1'b0;
      end
   end

   // Registered to keep the adder off the memory path; it settles one cycle after a base or index change.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fetch_addr_r <= 24'h000000;
      end else begin
         fetch_addr_r <= entry_addr(command_list_base_r, active_list_r ? list1_offset_r : 7'h00,
                                    command_list_index_r); // R10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The word is taken in the setup cycle and held, so prdata stands through the access phase.
   always_comb begin
      rd_word = 32'h00000000;
      unique case (paddr)
         acl_pkg::ctrl_off: rd_word = {26'h0, lower_system_option_bits_r, active_list_r, 1'b0,
                                       special_mode_access_r, adc_en_r};
         acl_pkg::status_off: rd_word = {24'h0, state_r, 3'b000, command_error_flag_r};
         acl_pkg::cmd_two_off: rd_word = {24'h0, cmd_two_r}; // R2
         acl_pkg::cmd_word_off: rd_word = {10'h0, chsel_r, cmd_two_r, 8'h00};
         acl_pkg::cmd_index_off: rd_word = {26'h0, command_list_index_r}; // R7
         acl_pkg::cbp_off: rd_word = {8'h00, command_list_base_r};
         acl_pkg::list1_off_off: rd_word = {25'h0, list1_offset_r};
         acl_pkg::prs_off: rd_word = {25'h0, clock_prescaler_value_r};
         default: rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prdata_r <= 32'h00000000;
      end else if (rd) begin
         prdata_r <= rd_word;
      end
   end

   assign prdata = prdata_r;
   assign fetch_req = state_r == acl_pkg::st_fetch;
   assign fetch_addr = fetch_addr_r;
   assign input_channel_select = cmd.input_channel_select; // R12
   assign system_option_bits = {cmd.upper_system_option_bits, lower_system_option_bits_r}; // R5
   assign sampling = state_r == acl_pkg::st_sample;
   assign sample_done = sample_done_r;
   assign command_error_flag = command_error_flag_r;
endmodule // acl_cmd_ctrl

// >>> tb/acl_cmd_ctrl_monitor.sv
`timescale 1ns/1ns
module acl_cmd_ctrl_monitor (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic fetch_req,
   input wire logic [23:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic [5:0] input_channel_select,
   input wire logic [3:0] system_option_bits,
   input wire logic sampling,
   input wire logic sample_done,
   input wire logic command_error_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_err; $rose(command_error_flag) |=> (!sampling && !fetch_req) [*3]; endproperty
   a_err: assert property (p_err) else $error("converter kept running after error");
   property p_halt; $rose(command_error_flag) |-> $past(sampling); endproperty
   a_halt: assert property (p_halt) else $error("error raised outside a sample window");
   property p_hold; fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr); endproperty
   a_hold: assert property (p_hold) else $error("fetch request dropped or moved");
   property p_step; fetch_req && fetch_ack |-> ##2 fetch_addr == $past(fetch_addr, 2) + 24'h4; endproperty
   a_step: assert property (p_step) else $error("fetch address did not step by one word");
   property p_done; sample_done |-> $past(sampling) && !sampling; endproperty
   a_done: assert property (p_done) else $error("done without sampling");
   property p_len; $rose(sampling) ##1 !$rose(command_error_flag) |-> sampling [*5]; endproperty
   a_len: assert property (p_len) else $error("sampling too short");
   property p_idx; psel && penable && !pwrite && paddr == acl_pkg::cmd_index_off |-> prdata[31:6] == 26'h0; endproperty
   a_idx: assert property (p_idx) else $error("index wider than six bits");
   property p_byte; psel && penable && !pwrite && paddr == acl_pkg::cmd_two_off |-> prdata[31:8] == 24'h0; endproperty
   a_byte: assert property (p_byte) else $error("command byte wider than eight bits");
   property p_opt; $changed(system_option_bits[3:2]) |-> $past(fetch_ack || pwrite); endproperty
   a_opt: assert property (p_opt) else $error("upper options changed unprompted");
   property p_chan; $changed(input_channel_select) |-> $past(fetch_req && fetch_ack || psel && pwrite); endproperty
   a_chan: assert property (p_chan) else $error("channel changed unprompted");
endmodule // acl_cmd_ctrl_monitor
bind acl_cmd_ctrl acl_cmd_ctrl_monitor u_mon (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .fetch_req, .fetch_addr, .fetch_ack, .input_channel_select, .system_option_bits, .sampling, .sample_done,
   .command_error_flag);

// >>> tb/acl_mem_model.sv
`timescale 1ns/1ns
module acl_mem_model (
   input wire logic ref_clk,
   input wire logic fetch_req,
   input wire logic [23:0] fetch_addr,
   input wire logic [3:0] delay,
   output logic fetch_ack,
   output logic [31:0] fetch_data
);
   // Both lists share one small array; the address wraps so any base fits.
   logic [31:0] mem [0:63];
   int wait_n = 0;
   initial begin
      fetch_ack = 1'b0;
      fetch_data = 32'h0;
   end
   always @(posedge ref_clk) begin
      fetch_ack <= 1'b0;
      // Data is only valid beside the strobe, so it toggles in between.
      fetch_data <= ~fetch_data;
      if (fetch_req === 1'b1 && !fetch_ack) begin
         wait_n <= wait_n + 1;
         if (wait_n >= delay) begin
            fetch_ack <= 1'b1;
            fetch_data <= mem[fetch_addr[7:2]];
            wait_n <= 0;
         end
      end
   end
endmodule // acl_mem_model

// >>> tb/adc_command_sample_and_list_pointer_test.sv
`timescale 1ns/1ns
module adc_command_sample_and_list_pointer_test;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, slverr, fetch_req, fetch_ack, sampling, done, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, fetch_data, rd, w;
   logic [23:0] fetch_addr, base;
   logic [5:0] chsel;
   logic [3:0] opt, delay;
   logic [6:0] prs;
   logic [1:0] lopt;
   logic lst;
   logic [31:0] exp_q[$];
   int n_fail, check_count, len, k;
   acl_cmd_ctrl u_dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fetch_req, .fetch_addr, .fetch_ack, .fetch_data, .input_channel_select(chsel), .system_option_bits(opt),
      .sampling, .sample_done(done), .command_error_flag(err));
   acl_mem_model u_mem (.ref_clk, .fetch_req, .fetch_addr, .delay, .fetch_ack, .fetch_data);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
      if (i == 50) begin
         n_fail++;
         finish_test();
      end
   endtask
   // A missed pulse would otherwise hang the run, so every wait is capped.
   task automatic wait_sig(input logic which);
      int i;
      for (i = 0; i < 3000 && (which ? err : done) !== 1'b1; i++) @(posedge ref_clk);
      if (i == 3000) begin
         n_fail++;
         finish_test();
      end
   endtask
   always @(posedge ref_clk) begin
      if (sampling === 1'b1) len++;
      if (done === 1'b1) begin
         check({16'(len), 6'h0, opt, chsel}, exp_q.pop_front());
         len = 0;
      end
   end
   //////////////////////////////////////////////////////////////////////
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, delay} = '0;
      {n_fail, check_count, len} = '0;
      void'($urandom(32'h8d1e));
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      apb(0, acl_pkg::cmd_two_off, 0);
      check(rd, {24'h0, acl_pkg::cmd_two_rst});
      apb(0, acl_pkg::cbp_off, 0);
      check(rd, {8'h0, acl_pkg::cbp_rst});
      apb(0, acl_pkg::list1_off_off, 0);
      check(rd, {25'h0, acl_pkg::list1_off_rst});
      apb(0, 8'h40, 0);
      check(rd, 32'h0);
      check({31'h0, slverr}, 32'h1);
      base = 24'($urandom) & 24'hfffffc;
      prs = 7'($urandom_range(2));
      apb(1, acl_pkg::cbp_off, {8'h0, base});
      apb(1, acl_pkg::prs_off, {25'h0, prs});
      apb(1, acl_pkg::cmd_two_off, 32'hff);
      apb(0, acl_pkg::cmd_two_off, 0);
      check(rd, 0);
      apb(1, acl_pkg::ctrl_off, 32'h2);
      apb(1, acl_pkg::cmd_two_off, 32'h52);
      apb(1, acl_pkg::cmd_word_off, 32'h00145200);
      apb(0, acl_pkg::cmd_word_off, 0);
      check(rd, 32'h00145200);
      apb(0, acl_pkg::cmd_two_off, 0);
      check(rd, 32'h52);
      apb(1, acl_pkg::ctrl_off, 32'h1);
      apb(1, acl_pkg::cbp_off, {8'h0, ~base});
      apb(0, acl_pkg::cbp_off, 0);
      check(rd, {8'h0, base});
      $display("register test done");
      for (k = 0; k < 64; k++) u_mem.mem[k] = {10'h0, 6'h10 + 6'($urandom_range(4)), 5'($urandom_range(20)),
         2'($urandom), 9'h0};
      lopt = 2'($urandom);
      for (k = 0; k < 6; k++) begin
         lst = k > 2;
         if (k == 3) apb(1, acl_pkg::ctrl_off, 0);
         apb(0, acl_pkg::cmd_index_off, 0);
         check(rd, k % 3);
         w = u_mem.mem[6'(base[7:2] + (lst ? 6'h20 : 6'h0) + k % 3)];
         exp_q.push_back({16'((w[15:11] + 4) * 2 * (prs + 1)), 6'h0, w[10:9], lopt, w[21:16]});
         delay <= 4'($urandom_range(3));
         apb(1, acl_pkg::ctrl_off, {26'h0, lopt, lst, 3'h1});
         apb(1, acl_pkg::ctrl_off, {26'h0, lopt, lst, 3'h5});
         wait_sig(0);
      end
      $display("conversion test done");
      for (k = 0; k < 3; k++) begin
         apb(1, acl_pkg::ctrl_off, 0);
         apb(1, acl_pkg::status_off, 1);
         u_mem.mem[base[7:2]] = k == 0 ? 32'h0010a800 : (k == 1 ? 32'h00050000 : 32'h00200000);
         apb(1, acl_pkg::ctrl_off, 1);
         apb(1, acl_pkg::ctrl_off, 5);
         wait_sig(1);
         apb(0, acl_pkg::status_off, 0);
         check({31'h0, rd[0]}, 32'h1);
      end
      $display("error test done");
      finish_test();
   end
endmodule // adc_command_sample_and_list_pointer_test
